// >>> include/afi_phy_params.svh
// Constants for the PHY side of the controller-to-PHY link: widths, offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz pclk and a full-rate, double-data-rate memory.
`ifndef AFI_PHY_PARAMS_SVH
`define AFI_PHY_PARAMS_SVH

// Ratios: rate (1/2/4), data rate (1/2), address rate (1/2)
`define AFI_RATE_RATIO 1
`define DATA_RATE_RATIO 2
`define ADDR_RATE_RATIO 1

// Memory-side sizes
`define MEM_ADDR_BITS 13
`define MEM_BANK_BITS 3
`define MEM_CS_COUNT 1
`define MEM_WDQS_GROUPS 1
`define MEM_CLK_PAIRS 1
`define MEM_DQ_BITS 8
`define MEM_DM_BITS 1

// Derived link widths
`define AFI_ADDR_W (`MEM_ADDR_BITS * `AFI_RATE_RATIO * `ADDR_RATE_RATIO)
`define AFI_BANK_W (`MEM_BANK_BITS * `AFI_RATE_RATIO * `ADDR_RATE_RATIO)
`define AFI_CTRL_W (`AFI_RATE_RATIO * `ADDR_RATE_RATIO)
`define AFI_CS_W (`MEM_CS_COUNT * `AFI_RATE_RATIO)
`define AFI_DQ_W (`MEM_DQ_BITS * `AFI_RATE_RATIO * `DATA_RATE_RATIO)
`define WRITE_BYTE_MASK_W (`MEM_DM_BITS * `AFI_RATE_RATIO * `DATA_RATE_RATIO)
`define AFI_WDQS_W (`MEM_WDQS_GROUPS * `AFI_RATE_RATIO)
`define LATENCY_FIELD_BITS 6
`define AFI_RLAT_W `LATENCY_FIELD_BITS
`define AFI_WLAT_W (`LATENCY_FIELD_BITS * `MEM_WDQS_GROUPS)

// Read return store
`define RD_MEM_AW 6
`define RD_MEM_DW (`AFI_DQ_W + 1)

// Timing
`define PCLK_PERIOD_NS 10
`define CAL_TIME_NS 1000
`define CAL_AFI_CYCLES ((`CAL_TIME_NS + 2 * `PCLK_PERIOD_NS - 1) / (2 * `PCLK_PERIOD_NS))
`define CAL_CNT_W 8

// APB register offsets
`define REG_CTRL 8'h00
`define REG_LATCFG 8'h04
`define REG_STATUS 8'h08
`define REG_IDENT 8'h0C

// Field positions
`define CTRL_FORCE_FAIL 0
`define CTRL_CAL_HOLD 1
`define LATCFG_RLAT_LSB 0
`define LATCFG_WLAT_LSB 6
`define STATUS_SUCCESS 0
`define STATUS_FAIL 1
`define STATUS_STATE_LSB 2
`define STATUS_RLAT_LSB 8
`define STATUS_WLAT_LSB 14

// Reset values; identity value is arbitrary
`define CTRL_RESET 2'h0
`define LATCFG_RESET 12'h104
`define IDENT_VALUE 32'h00C0_FFEE

`endif

// >>> include/afi_phy_pkg.sv
// Types shared by the PHY link logic.
// Assumes afi_phy_params.svh supplies all numeric constants.
package afi_phy_pkg;

  // Sequencer states, Gray coded along hold, run, pass
  typedef enum logic [1:0] {
    CAL_HOLD = 2'h0,
    CAL_RUN = 2'h1,
    CAL_PASS = 2'h3,
    CAL_FAIL = 2'h2
  } cal_state_t;

endpackage

// >>> verilog/rd_return_mem.sv
// Small store holding captured read words with their enable flags.
// Assumes one clock; read data comes out of a register one edge later.
`timescale 1ns/1ps
`default_nettype none

module rd_return_mem #(
  parameter int DW = 17,
  parameter int AW = 6
) (
  input wire logic clk, // Store clock
  input wire logic rst_n, // Async reset, clears read register only
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [DW-1:0] wdata, // Write data
  input wire logic re, // Read strobe
  input wire logic [AW-1:0] raddr, // Read address
  output logic [DW-1:0] rdata // Registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Array has no reset; unwritten words read back as unknown
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// >>> verilog/afi_phy_core.sv
// PHY end of the controller link: clocks, reset, command, write, read return
// and calibration status, plus an APB register window.
// Assumes the controller runs on afi_clk, which this block derives from pclk.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "afi_phy_params.svh"

// Behaviour
// R01: Rate ratio is 1, 2 or 4 relating link clock to memory clock.
// R02: Data rate ratio is 1 for single, 2 for double data rate.
// R03: Address rate ratio is 1 for single, 2 for double rate address.
// R04: Address, bank, control and chip-select widths follow the ratio products.
// R05: Data, mask and strobe-group widths follow the ratio products.
// R06: Latency field is 6 bits; write latency is 6 bits per group.
// R07: PHY drives the link clock; all link transfers use it.
// R08: Optional half-rate clock output for the controller's bridge.
// R09: PHY drives active-low async reset; controller synchronises it.
// R10: Address and command lanes carry one value per link clock.
// R11: Clock-disable stops driving the memory clock pair.
// R12: Strobe-burst makes the PHY drive the group's strobe pair.
// R13: Controller raises strobe-burst ahead of write-valid for the preamble.
// R14: Data and mask drivers enabled only while write-valid is high.
// R15: Write data and mask leave at double data rate.
// R16: Read-enable is high only for wanted read beats.
// R17: Full read-enable stays high for the whole read burst.
// R18: Read-valid flags read data; data means nothing otherwise.
// R19: Success flag on good calibration, failure flag otherwise.
// R20: Calibration request holds the sequencer; release starts calibration.
// R21: Report write latency per group, 0 to 63 link clocks.
// R22: Report read latency, 0 to 63 link clocks.
// R23: One value per lane per rising link clock edge.
// R24: Low part of a wide bus goes to memory first.
// R25: Success and failure never together; cleared during request or reset.
// R26: Controller issues no reads or writes before calibration success.
module afi_phy_core (
  input wire logic pclk, // 100 MHz core clock
  input wire logic presetn, // Async reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error, unmapped offset
  output logic afi_clk, // Link clock, pclk / 2
  output logic afi_half_clk, // Half of link clock
  output logic afi_reset_n, // Link reset, active low
  input wire logic [`AFI_ADDR_W-1:0] afi_addr, // Address lanes
  input wire logic [`AFI_BANK_W-1:0] afi_ba, // Bank lanes
  input wire logic [`AFI_CS_W-1:0] afi_cke, // Clock enable lanes
  input wire logic [`AFI_CS_W-1:0] afi_cs_n, // Chip select lanes
  input wire logic [`AFI_CTRL_W-1:0] afi_ras_n, // Row strobe lane
  input wire logic [`AFI_CTRL_W-1:0] afi_cas_n, // Column strobe lane
  input wire logic [`AFI_CTRL_W-1:0] afi_we_n, // Write enable lane
  input wire logic [`AFI_CTRL_W-1:0] afi_rst_n, // Memory reset lane
  input wire logic [`AFI_CS_W-1:0] afi_odt, // Termination lanes
  input wire logic [`MEM_CLK_PAIRS-1:0] afi_mem_clk_disable, // Memory clock stop
  input wire logic [`AFI_WDQS_W-1:0] afi_dqs_burst, // Strobe drive per group
  input wire logic [`AFI_WDQS_W-1:0] afi_wdata_valid, // Write valid per group
  input wire logic [`AFI_DQ_W-1:0] afi_wdata, // Write data, low half first
  input wire logic [`WRITE_BYTE_MASK_W-1:0] write_byte_mask, // Write mask, low half first
  input wire logic [`AFI_RATE_RATIO-1:0] afi_rdata_en, // Wanted read beats
  input wire logic [`AFI_RATE_RATIO-1:0] afi_rdata_en_full, // Whole read burst
  output logic [`AFI_DQ_W-1:0] afi_rdata, // Read data
  output logic [`AFI_RATE_RATIO-1:0] afi_rdata_valid, // Read data valid
  output logic afi_cal_success, // Calibration passed
  output logic afi_cal_fail, // Calibration failed
  input wire logic afi_cal_req, // Hold sequencer in reset
  output logic [`AFI_WLAT_W-1:0] afi_wlat, // Write latency per group
  output logic [`AFI_RLAT_W-1:0] afi_rlat, // Read latency
  output logic [`MEM_CLK_PAIRS-1:0] mem_ck, // Memory clock
  output logic [`MEM_CLK_PAIRS-1:0] mem_ck_n, // Memory clock complement
  output logic [`MEM_CLK_PAIRS-1:0] mem_ck_oe_n, // Clock driver enable, low drives
  output logic [`MEM_ADDR_BITS-1:0] mem_addr, // Memory address
  output logic [`MEM_BANK_BITS-1:0] mem_ba, // Memory bank
  output logic [`MEM_CS_COUNT-1:0] mem_cke, // Memory clock enable
  output logic [`MEM_CS_COUNT-1:0] mem_cs_n, // Memory chip select
  output logic mem_ras_n, // Memory row strobe
  output logic mem_cas_n, // Memory column strobe
  output logic mem_we_n, // Memory write enable
  output logic mem_rst_n, // Memory reset
  output logic [`MEM_CS_COUNT-1:0] mem_odt, // Memory termination
  output logic [`MEM_DQ_BITS-1:0] mem_dq_out, // Data pin drive value
  output logic [`MEM_DQ_BITS-1:0] mem_dq_oe_n, // Data driver enable, low drives
  input wire logic [`MEM_DQ_BITS-1:0] mem_dq_in, // Data pin level
  output logic [`MEM_DM_BITS-1:0] mem_dm_out, // Mask pin drive value
  output logic [`MEM_DM_BITS-1:0] mem_dm_oe_n, // Mask driver enable, low drives
  output logic [`MEM_WDQS_GROUPS-1:0] mem_dqs_out, // Strobe drive value
  output logic [`MEM_WDQS_GROUPS-1:0] mem_dqs_n_out, // Strobe complement value
  output logic [`MEM_WDQS_GROUPS-1:0] mem_dqs_oe_n // Strobe driver enable, low drives
);

  // R01 R02 R03 R04 R05 R06 derived widths
  localparam int DQG = `MEM_DQ_BITS / `MEM_WDQS_GROUPS;
  localparam int DMG = `MEM_DM_BITS / `MEM_WDQS_GROUPS;

  logic afi_clk_q;
  logic half_q;
  logic rise_en;
  logic [1:0] rst_sync_q;
  afi_phy_pkg::cal_state_t st_q;
  logic [`CAL_CNT_W-1:0] cal_cnt_q;
  logic succ_q;
  logic fail_q;
  logic [`AFI_RLAT_W-1:0] rlat_q;
  logic [`AFI_WLAT_W-1:0] wlat_q;
  logic [1:0] ctrl_q;
  logic [11:0] latcfg_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [`MEM_CLK_PAIRS-1:0] ck_oe_n_q;
  logic [`MEM_DQ_BITS-1:0] dq_s1_q;
  logic [`MEM_DQ_BITS-1:0] dq_s2_q;
  logic [`MEM_DQ_BITS-1:0] rd_lo_q;
  logic [`RD_MEM_AW-1:0] wptr_q;
  logic [`RD_MEM_AW-1:0] rlat_eff;
  logic [`RD_MEM_DW-1:0] rd_word;
  logic cal_hold_req;

  // Link clock from a divider; rise_en marks the pclk edge where it rises
  assign rise_en = ~afi_clk_q;
  assign afi_clk = afi_clk_q;
  assign afi_half_clk = half_q;

  // R07 link clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afi_clk_q <= 1'b0;
    end else begin
      afi_clk_q <= ~afi_clk_q;
    end
  end

  // R08 half clock toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else if (rise_en) begin
      half_q <= ~half_q;
    end
  end

  // R09 reset out, released two edges after presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign afi_reset_n = rst_sync_q[1];

  // R10 R23 command lanes taken once per link clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= '0;
      mem_ba <= '0;
      mem_cke <= '0;
      mem_cs_n <= '1;
      mem_ras_n <= 1'b1;
      mem_cas_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_rst_n <= 1'b0;
      mem_odt <= '0;
      ck_oe_n_q <= '0;
    end else if (rise_en) begin
      mem_addr <= afi_addr;
      mem_ba <= afi_ba;
      mem_cke <= afi_cke;
      mem_cs_n <= afi_cs_n;
      mem_ras_n <= afi_ras_n[0];
      mem_cas_n <= afi_cas_n[0];
      mem_we_n <= afi_we_n[0];
      mem_rst_n <= afi_rst_n[0];
      mem_odt <= afi_odt;
      ck_oe_n_q <= afi_mem_clk_disable;
    end
  end

  // R11 memory clock follows link clock; disable releases the pair
  assign mem_ck = {`MEM_CLK_PAIRS{afi_clk_q}};
  assign mem_ck_n = {`MEM_CLK_PAIRS{~afi_clk_q}};
  assign mem_ck_oe_n = ck_oe_n_q;

  // Write path, one copy per strobe group
  genvar g;
  generate
    for (g = 0; g < `MEM_WDQS_GROUPS; g++) begin : g_wgrp
      logic [DQG-1:0] dq_q;
      logic [DQG-1:0] dq_hi_q;
      logic [DQG-1:0] dq_oe_n_q;
      logic [DMG-1:0] dm_q;
      logic [DMG-1:0] dm_hi_q;
      logic [DMG-1:0] dm_oe_n_q;
      logic dqs_q;
      logic dqs_n_q;
      logic dqs_oe_n_q;
      // R15 R24 low half in high phase, high half in low phase
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dq_q <= '0;
          dq_hi_q <= '0;
          dm_q <= '0;
          dm_hi_q <= '0;
        end else if (rise_en) begin
          dq_q <= afi_wdata[g*DQG +: DQG];
          dq_hi_q <= afi_wdata[`MEM_DQ_BITS + g*DQG +: DQG];
          dm_q <= write_byte_mask[g*DMG +: DMG];
          dm_hi_q <= write_byte_mask[`MEM_DM_BITS + g*DMG +: DMG];
        end else begin
          dq_q <= dq_hi_q;
          dm_q <= dm_hi_q;
        end
      end
      // R14 drivers on only while write valid
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dq_oe_n_q <= '1;
          dm_oe_n_q <= '1;
        end else if (rise_en) begin
          dq_oe_n_q <= {DQG{~afi_wdata_valid[g]}};
          dm_oe_n_q <= {DMG{~afi_wdata_valid[g]}};
        end
      end
      // R12 strobe pair driven during burst; low before valid gives preamble
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dqs_q <= 1'b0;
          dqs_n_q <= 1'b1;
          dqs_oe_n_q <= 1'b1;
        end else if (rise_en) begin
          dqs_q <= afi_wdata_valid[g];
          dqs_n_q <= ~afi_wdata_valid[g];
          dqs_oe_n_q <= ~afi_dqs_burst[g];
        end else begin
          dqs_q <= 1'b0;
          dqs_n_q <= 1'b1;
        end
      end
      assign mem_dq_out[g*DQG +: DQG] = dq_q;
      assign mem_dq_oe_n[g*DQG +: DQG] = dq_oe_n_q;
      assign mem_dm_out[g*DMG +: DMG] = dm_q;
      assign mem_dm_oe_n[g*DMG +: DMG] = dm_oe_n_q;
      assign mem_dqs_out[g] = dqs_q;
      assign mem_dqs_n_out[g] = dqs_n_q;
      assign mem_dqs_oe_n[g] = dqs_oe_n_q;
    end
  endgenerate

  // Pin levels pass two flops before capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= mem_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // R24 first beat of a link cycle lands in the low half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_lo_q <= '0;
      wptr_q <= '0;
    end else if (rise_en) begin
      wptr_q <= wptr_q + 1'b1;
    end else begin
      rd_lo_q <= dq_s2_q;
    end
  end

  // R18 valid flag rides with the word; only enabled beats inside a burst
  assign rd_word = {afi_rdata_en[0] & afi_rdata_en_full[0], dq_s2_q, rd_lo_q};
  // R22 return delay follows reported latency; zero acts as one
  assign rlat_eff = (rlat_q == '0) ? `RD_MEM_AW'(1) : rlat_q;

  rd_return_mem #(
    .DW(`RD_MEM_DW),
    .AW(`RD_MEM_AW)
  ) u_rd_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(rise_en),
    .waddr(wptr_q),
    .wdata(rd_word),
    .re(rise_en),
    .raddr(wptr_q - rlat_eff),
    .rdata({afi_rdata_valid[0], afi_rdata})
  );

  // Software hold acts like a controller request
  assign cal_hold_req = afi_cal_req | ctrl_q[`CTRL_CAL_HOLD];

  // R20 R19 sequencer, stepped once per link clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= afi_phy_pkg::CAL_HOLD;
      cal_cnt_q <= '0;
      succ_q <= 1'b0;
      fail_q <= 1'b0;
      rlat_q <= '0;
      wlat_q <= '0;
    end else if (rise_en) begin
      if (cal_hold_req) begin
        // R25 both flags clear while held
        st_q <= afi_phy_pkg::CAL_HOLD;
        cal_cnt_q <= '0;
        succ_q <= 1'b0;
        fail_q <= 1'b0;
      end else begin
        case (st_q)
          afi_phy_pkg::CAL_HOLD: begin
            st_q <= afi_phy_pkg::CAL_RUN;
          end
          afi_phy_pkg::CAL_RUN: begin
            if (cal_cnt_q == `CAL_CNT_W'(`CAL_AFI_CYCLES - 1)) begin
              if (ctrl_q[`CTRL_FORCE_FAIL]) begin
                st_q <= afi_phy_pkg::CAL_FAIL;
                fail_q <= 1'b1;
              end else begin
                // R21 R22 latencies fixed at pass
                st_q <= afi_phy_pkg::CAL_PASS;
                succ_q <= 1'b1;
                rlat_q <= latcfg_q[`LATCFG_RLAT_LSB +: `AFI_RLAT_W];
                wlat_q <= latcfg_q[`LATCFG_WLAT_LSB +: `AFI_WLAT_W];
              end
            end else begin
              cal_cnt_q <= cal_cnt_q + 1'b1;
            end
          end
          default: begin
            st_q <= st_q;
          end
        endcase
      end
    end
  end
  assign afi_cal_success = succ_q;
  assign afi_cal_fail = fail_q;
  assign afi_rlat = rlat_q;
  assign afi_wlat = wlat_q;

  // APB: zero wait states, decode registered in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      err_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (paddr == `REG_CTRL) begin
        prdata_q[1:0] <= ctrl_q;
      end else if (paddr == `REG_LATCFG) begin
        prdata_q[11:0] <= latcfg_q;
      end else if (paddr == `REG_STATUS) begin
        prdata_q[`STATUS_SUCCESS] <= succ_q;
        prdata_q[`STATUS_FAIL] <= fail_q;
        prdata_q[`STATUS_STATE_LSB +: 2] <= st_q;
        prdata_q[`STATUS_RLAT_LSB +: `AFI_RLAT_W] <= rlat_q;
        prdata_q[`STATUS_WLAT_LSB +: `AFI_WLAT_W] <= wlat_q;
      end else if (paddr == `REG_IDENT) begin
        prdata_q <= `IDENT_VALUE;
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  // Writable registers; read-only offsets ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      latcfg_q <= `LATCFG_RESET;
    end else if (psel && penable && pwrite) begin
      if (paddr == `REG_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end else if (paddr == `REG_LATCFG) begin
        latcfg_q <= pwdata[11:0];
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_two_low(logic a);
    !a [*2];
  endsequence

  property p_cal_excl;
    !(afi_cal_success && afi_cal_fail);
  endproperty
  a_cal_excl: assert property (p_cal_excl) else $error("success and fail together"); // R25

  property p_req_clears;
    rise_en && afi_cal_req |=> !afi_cal_success && !afi_cal_fail;
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("flags not cleared by request"); // R20

  property p_pass_after_run;
    $rose(afi_cal_success) |-> $past(st_q) == afi_phy_pkg::CAL_RUN && !$past(cal_hold_req);
  endproperty
  a_pass_after_run: assert property (p_pass_after_run) else $error("success without run"); // R19

  property p_lat_report;
    $rose(afi_cal_success) |-> afi_rlat == $past(latcfg_q[5:0]) && afi_wlat == $past(latcfg_q[11:6]);
  endproperty
  a_lat_report: assert property (p_lat_report) else $error("latency not reported"); // R22

  property p_dq_drive;
    rise_en && afi_wdata_valid[0] |=> s_two_low(mem_dq_oe_n[0]);
  endproperty
  a_dq_drive: assert property (p_dq_drive) else $error("data not driven while valid"); // R14

  property p_dq_release;
    rise_en && !afi_wdata_valid[0] |=> mem_dq_oe_n[0] && mem_dm_oe_n[0];
  endproperty
  a_dq_release: assert property (p_dq_release) else $error("data driven without valid"); // R14

  property p_dqs_drive;
    rise_en && afi_dqs_burst[0] |=> s_two_low(mem_dqs_oe_n[0]);
  endproperty
  a_dqs_drive: assert property (p_dqs_drive) else $error("strobe not driven in burst"); // R12

  property p_ddr_order;
    rise_en && afi_wdata_valid[0] |=>
      mem_dq_out == $past(afi_wdata[7:0]) ##1 mem_dq_out == $past(afi_wdata[15:8], 2);
  endproperty
  a_ddr_order: assert property (p_ddr_order) else $error("write beats out of order"); // R15

  property p_cmd_sdr;
    rise_en |=> mem_addr == $past(afi_addr) && mem_ba == $past(afi_ba);
  endproperty
  a_cmd_sdr: assert property (p_cmd_sdr) else $error("command lane not taken"); // R10

  property p_ck_stop;
    rise_en && afi_mem_clk_disable[0] |=> mem_ck_oe_n[0] [*2];
  endproperty
  a_ck_stop: assert property (p_ck_stop) else $error("memory clock still driven"); // R11

  property p_half_clk;
    rise_en |=> afi_half_clk != $past(afi_half_clk) ##1 $stable(afi_half_clk);
  endproperty
  a_half_clk: assert property (p_half_clk) else $error("half clock wrong rate"); // R08

endmodule

`default_nettype wire

// >>> verification/ctrl_model.sv
// Controller-side model: one write with preamble, then one read window.
// Assumes afi_clk is sampled by pclk; lanes change on the edge where afi_clk falls.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic pclk, // Core clock
  input wire logic afi_clk, // Link clock
  input wire logic afi_reset_n, // Link reset, active low
  input wire logic cal_ok, // Calibration passed
  input wire logic go, // Start one sequence
  input wire logic full_on, // Raise full read enable too
  input wire logic [15:0] wd, // Write word
  input wire logic [1:0] mk, // Write mask
  input wire logic [7:0] dpat, // Memory read level
  output logic busy, // Sequence running
  output logic dqs_burst, // Strobe drive
  output logic wvalid, // Write valid
  output logic [15:0] wdata, // Write data
  output logic [1:0] wmask, // Write mask
  output logic ren, // Read enable
  output logic ren_full, // Read enable full
  output logic [7:0] dq_in // Memory data level
);
  logic [1:0] rst_sync_q;
  logic [2:0] st_q;
  always_ff @(posedge pclk or negedge afi_reset_n) begin
    if (!afi_reset_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  always_ff @(posedge pclk) begin
    if (!rst_sync_q[1]) st_q <= 3'h0;
    else if (afi_clk && (st_q != 3'h0 || (go && cal_ok))) st_q <= st_q + 3'h1;
  end
  assign busy = st_q != 3'h0;
  assign dqs_burst = st_q == 3'h1 || st_q == 3'h2;
  assign wvalid = st_q == 3'h2;
  // Lanes outside the data beat carry junk
  assign wdata = wvalid ? wd : ~wd;
  assign wmask = wvalid ? mk : ~mk;
  // wanted beat, full only on request
  assign ren = st_q == 3'h5;
  assign ren_full = ren && full_on;
  // Idle bus keeps changing so a stale level never passes
  always_ff @(posedge pclk) begin
    if (!rst_sync_q[1]) dq_in <= 8'h5A;
    else dq_in <= (st_q >= 3'h2 && st_q <= 3'h6) ? dpat : ~dq_in;
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Bench for the PHY link core: APB setup, calibration, write, read, clock stop.
// Assumes ctrl_model drives the data lanes; the bench drives command lanes.
`timescale 1ns/1ps
`default_nettype none
`include "afi_phy_params.svh"
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, exp, got); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, run_q, go, full, dis, creq;
  logic afi_clk, half, rstn, ok, fl, wv, burst, ren, renf, busy, ck, ckn, ckoe, dmoe, dqs, dqsn, dqsoe;
  logic [7:0] paddr, dp, dqo, dqoe, dqi;
  logic [31:0] pwdata, prdata, rd;
  logic [22:0] cmd_q;
  logic [12:0] maddr;
  logic [2:0] mba;
  logic [6:0] mctl;
  logic [15:0] wd, wdat, rdat;
  logic [1:0] mk, wm;
  logic [5:0] rl, wl, rlat, wlat;
  logic dmo, rv;
  int n_fail = 0, n_tests = 0, seed, nb, nv, na = 0, nh = 0;
  afi_phy_core afi_phy_core_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .afi_clk(afi_clk), .afi_half_clk(half), .afi_reset_n(rstn),
    .afi_addr(cmd_q[22:10]), .afi_ba(cmd_q[9:7]), .afi_cke(cmd_q[6]), .afi_cs_n(cmd_q[5]),
    .afi_ras_n(cmd_q[4]), .afi_cas_n(cmd_q[3]), .afi_we_n(cmd_q[2]), .afi_rst_n(cmd_q[1]),
    .afi_odt(cmd_q[0]), .afi_mem_clk_disable(dis), .afi_dqs_burst(burst), .afi_wdata_valid(wv),
    .afi_wdata(wdat), .write_byte_mask(wm), .afi_rdata_en(ren), .afi_rdata_en_full(renf),
    .afi_rdata(rdat), .afi_rdata_valid(rv), .afi_cal_success(ok), .afi_cal_fail(fl),
    .afi_cal_req(creq), .afi_wlat(wlat), .afi_rlat(rlat), .mem_ck(ck), .mem_ck_n(ckn),
    .mem_ck_oe_n(ckoe), .mem_addr(maddr), .mem_ba(mba), .mem_cke(mctl[6]), .mem_cs_n(mctl[5]),
    .mem_ras_n(mctl[4]), .mem_cas_n(mctl[3]), .mem_we_n(mctl[2]), .mem_rst_n(mctl[1]),
    .mem_odt(mctl[0]), .mem_dq_out(dqo), .mem_dq_oe_n(dqoe), .mem_dq_in(dqi), .mem_dm_out(dmo),
    .mem_dm_oe_n(dmoe), .mem_dqs_out(dqs), .mem_dqs_n_out(dqsn), .mem_dqs_oe_n(dqsoe));
  ctrl_model ctrl_model_inst (.pclk(pclk), .afi_clk(afi_clk), .afi_reset_n(rstn), .cal_ok(ok),
    .go(go), .full_on(full), .wd(wd), .mk(mk), .dpat(dp), .busy(busy), .dqs_burst(burst),
    .wvalid(wv), .wdata(wdat), .wmask(wm), .ren(ren), .ren_full(renf), .dq_in(dqi));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge afi_clk) na++;
  always @(posedge half) nh++;
  // New command word each link cycle
  always @(posedge pclk) if (run_q && afi_clk === 1'b1) cmd_q <= 23'($random(seed));
  // Lanes checked mid-cycle, where they are settled
  always @(negedge pclk) begin
    if (run_q && afi_clk === 1'b1) `CHK("cmd", {maddr, mba, mctl}, cmd_q)
    if (dqoe === 8'h00) begin
      `CHK("dq", dqo, nb[0] ? wd[15:8] : wd[7:0])
      `CHK("dm", {dmoe, dmo}, {1'b0, mk[nb[0]]})
      `CHK("dqs", {dqsoe, dqs, dqsn}, {1'b0, ~nb[0], nb[0]})
      nb++;
    end
    if (dqsoe === 1'b0 && nb == 0) `CHK("preamble", {dqoe, dqs}, 9'h1FE)
    if (afi_clk === 1'b1 && rv === 1'b1) begin
      nv++;
      `CHK("rdata", rdat, {dp, dp})
    end
  end
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? busy : k == 1 ? (ok | fl) : rstn;
  endfunction
  // Bounded wait; running out ends the run
  task automatic wait_for(input int k, input logic v);
    for (int i = 0; i < 500; i++) begin
      @(negedge pclk);
      if (sig(k) === v) return;
    end
    n_fail++;
    conclude();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !rdy; i++) begin
      @(posedge pclk);
      rdy = pready === 1'b1;
      rd = prdata;
      er = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!rdy) begin
      n_fail++;
      conclude();
    end
  endtask
  // One write, one read; valid only with full enable
  task automatic run_rw(input logic f);
    @(posedge pclk);
    nb = 0;
    nv = 0;
    wd <= 16'($random(seed));
    mk <= 2'($random(seed));
    dp <= 8'($random(seed));
    full <= f;
    go <= 1'b1;
    wait_for(0, 1'b1);
    @(posedge pclk);
    go <= 1'b0;
    wait_for(0, 1'b0);
    repeat (200) @(posedge pclk);
    `CHK("beats", nb, 2)
    `CHK("valid count", nv, int'(f))
    $display("test read full=%0d done", f);
  endtask
  initial begin
    seed = 31402;
    {presetn, psel, penable, pwrite, go, full, dis, run_q} = 8'h00;
    {paddr, pwdata, cmd_q, wd, mk, dp} = 0;
    creq = 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("reset out", rstn, 1'b0)
    `CHK("reset flags", {ok, fl}, 2'b00)
    presetn <= 1'b1;
    run_q <= 1'b1;
    wait_for(2, 1'b1);
    apb(1'b1, `REG_IDENT, 32'h0);
    apb(1'b0, `REG_IDENT, 32'h0);
    `CHK("ident", rd, `IDENT_VALUE)
    apb(1'b0, `REG_LATCFG, 32'h0);
    `CHK("latcfg reset", rd, 32'(`LATCFG_RESET))
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", {er, rd}, {1'b1, 32'h0})
    rl = 6'($unsigned($random(seed)) % 63 + 1);
    wl = 6'($random(seed));
    apb(1'b1, `REG_LATCFG, {20'h0, wl, rl});
    `CHK("held", ok, 1'b0)
    $display("test regs done");
    @(posedge pclk);
    creq <= 1'b0;
    wait_for(1, 1'b1);
    `CHK("cal", {ok, fl, rlat, wlat}, {2'b10, rl, wl})
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("status", {rd[19:8], rd[3:0]}, {wl, rl, 4'hD})
    $display("test cal done");
    run_rw(1'b0);
    run_rw(1'b1);
    @(posedge pclk);
    dis <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("ck stop", ckoe, 1'b1)
    dis <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("ck run", ckoe, 1'b0)
    $display("test clock stop done");
    apb(1'b1, `REG_CTRL, 32'h3);
    repeat (6) @(posedge pclk);
    `CHK("hold flags", {ok, fl}, 2'b00)
    apb(1'b1, `REG_CTRL, 32'h1);
    wait_for(1, 1'b1);
    `CHK("fail flags", {ok, fl}, 2'b01)
    `CHK("half clock", nh, (na + 1) / 2)
    $display("test fail done");
    conclude();
  end
endmodule
`default_nettype wire
